// File: common/vsc_pkg.sv
package vsc_pkg;

  // ***************************************************************
  // command decoding
  // ***************************************************************
  localparam int unsigned VSC_NUM_CH = 4;
  localparam int unsigned VSC_VOL_W = 5;
  localparam int unsigned VSC_ATT_W = 12;
  localparam int unsigned VSC_BYTE_W = 8;

  localparam logic [3:0] VSC_VOL_NIBBLE = 4'hA;
  localparam logic [6:0] VSC_STAT_READ_TOP = 7'h58;
  localparam logic [4:0] VSC_PIN_SEL_TOP = 5'h18;
  localparam logic [7:0] VSC_FAULT_CLEAR_OP = 8'hFF;
  // opcode value is arbitrary, adjust to match the command set
  localparam logic [7:0] VSC_POWER_UP_OP = 8'h30;
  localparam logic [2:0] VSC_VOL_PAD = 3'h0;

  // ***************************************************************
  // reset values and counts
  // ***************************************************************
  localparam logic [4:0] VSC_VOL_DEFAULT = 5'h1F;
  localparam logic [4:0] VSC_VOL_MUTE = 5'h00;
  localparam logic [2:0] VSC_BIT_LAST = 3'h7;
  localparam logic [2:0] VSC_PIN_SEL_RESET = 3'h0;
  localparam logic [4:0] VSC_STAT_PAD = 5'h00;

  // attenuation in hundredths of a dB, indexed by volume code
  localparam logic [11:0] VSC_ATT_MUTE = 12'hFFF;
  localparam logic [11:0] VSC_ATTEN_CDB [32] = '{
    12'hFFF, 12'hBA7, 12'h94D, 12'h7EC, 12'h6F3, 12'h631, 12'h592,
    12'h50D, 12'h499, 12'h432, 12'h3D7, 12'h384, 12'h338, 12'h2F3,
    12'h2B2, 12'h277, 12'h23E, 12'h20A, 12'h1D8, 12'h1A9, 12'h17D,
    12'h152, 12'h12A, 12'h103, 12'h0DE, 12'h0BB, 12'h099, 12'h078,
    12'h058, 12'h03A, 12'h01C, 12'h000};

  // ***************************************************************
  // carriers
  // ***************************************************************
  typedef struct packed {
    logic       first;
    logic [7:0] data;
  } vsc_word_t;

  typedef struct packed {
    logic overtemp;
    logic undervoltage;
    logic transfer;
    logic minus_short;
    logic plus_short;
  } vsc_fault_t;

endpackage : vsc_pkg

// File: dv/vsc_host_model.sv
`timescale 1ns/1ps
`default_nettype none

module vsc_host_model (
  output logic      sclk_o,
  output logic      csn_o,
  output logic      si_o,
  input  wire logic so_i
);
  initial
  begin
    sclk_o = 1'b0;
    csn_o  = 1'b1;
    si_o   = 1'b0;
  end

  // msb first; clock idles low, gap keeps bytes 5 core cycles apart
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--)
    begin
      si_o = tx[i];
      #32 rx[i] = so_i;
      sclk_o = 1'b1;
      #32 sclk_o = 1'b0;
    end
    #500;
  endtask : xfer

  // one command per frame; caller passes 00 as readout byte
  task automatic frame(input logic [7:0] b0, input logic [7:0] b1,
                       input bit two, output logic [7:0] rx);
    logic [7:0] unused;
    csn_o = 1'b0;
    #100;
    xfer(b0, unused);
    if (two)
      xfer(b1, rx);
    csn_o = 1'b1;
    #300;
  endtask : frame
endmodule : vsc_host_model

`default_nettype wire

// File: dv/vsc_top_tb.sv
`timescale 1ns/1ps
`default_nettype none

module vsc_top_tb;
  import vsc_pkg::*;
  logic             clock_i;
  logic             rst_i;
  logic             sclk;
  logic             csn;
  logic             si;
  logic             so;
  logic [3:0]       proc;
  logic [3:0]       play;
  logic             ot, uv, dual, terr, ms, ps;
  logic [3:0][4:0]  vol;
  logic [3:0][11:0] att;
  logic [3:0]       mute;
  vsc_fault_t       flags;
  logic             fault;
  logic             status;
  logic [7:0]       rx;
  int               mismatches;
  int               comparisons;
  int               cycles;

  vsc_top u_vsc_top (.clock_i(clock_i), .rst_i(rst_i), .sclk_i(sclk),
    .csn_i(csn), .si_i(si), .so_o(so), .ch_processing_i(proc),
    .ch_playing_i(play), .overtemp_detect_i(ot),
    .undervoltage_detect_i(uv), .dual_cmd_mode_i(dual),
    .transfer_error_i(terr), .minus_short_detect_i(ms),
    .plus_short_detect_i(ps), .volume_code_o(vol), .atten_cdb_o(att),
    .mute_o(mute), .fault_flags_o(flags), .fault_o(fault),
    .status_o(status));

  vsc_host_model u_vsc_host_model (.sclk_o(sclk), .csn_o(csn), .si_o(si),
    .so_i(so));

  // ***************************************************************
  // helpers
  // ***************************************************************
  always #50 clock_i = ~clock_i;

  always @(posedge clock_i)
  begin
    cycles++;
    if (cycles == 6000)
    begin
      mismatches++;
      give_verdict();
    end
  end

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : give_verdict

  task automatic chk(input string what, input logic [11:0] exp,
                     input logic [11:0] got);
    comparisons++;
    if (got !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask : tick

  // frame, then room for sync, register and attenuation stages
  task automatic cmd(input logic [7:0] b0, input logic [7:0] b1,
                     input bit two);
    u_vsc_host_model.frame(b0, b1, two, rx);
    tick(8);
  endtask : cmd

  task automatic vols(input logic [19:0] exp);
    for (int c = 0; c < 4; c++)
      chk("volume", {7'h00, exp[c*5 +: 5]}, {7'h00, vol[c]});
  endtask : vols

  // ***************************************************************
  // scenarios
  // ***************************************************************
  task automatic t_reset();
    vols({4{5'h1F}});
    chk("atten0", 12'h000, att[0]);
    chk("mute", 12'h000, {8'h00, mute});
    chk("pin", 12'h001, {11'h000, status});
    chk("flags", 12'h000, {7'h00, flags, fault});
  endtask : t_reset

  task automatic t_volume();
    cmd(8'hA5, 8'h0A, 1'b1);
    vols({5'h1F, 5'h0A, 5'h1F, 5'h0A});
    chk("atten0", 12'h3D7, att[0]);
    cmd(8'hAA, 8'h1E, 1'b1);
    vols({5'h1E, 5'h0A, 5'h1E, 5'h0A});
    chk("atten1", 12'h01C, att[1]);
    cmd(8'hA8, 8'h00, 1'b1);
    chk("mute3", 12'h008, {8'h00, mute});
    chk("atten3", 12'hFFF, att[3]);
    cmd(8'hA1, 8'h01, 1'b1);
    chk("atten0", 12'hBA7, att[0]);
    cmd(8'hA1, 8'h2A, 1'b1);
    chk("padded", 12'h001, {7'h00, vol[0]});
    cmd(8'h30, 8'h00, 1'b0);
    vols({4{5'h1F}});
    chk("unmute", 12'h000, {8'h00, mute});
  endtask : t_volume

  task automatic t_status();
    proc = 4'b0101;
    play = 4'b0011;
    tick(5);
    cmd(8'hB0, 8'h00, 1'b1);
    chk("status0", 12'h0CA, {4'h0, rx});
  endtask : t_status

  task automatic t_faults();
    terr = 1'b1;
    tick(2);
    terr = 1'b0;
    chk("no dual", 12'h000, {11'h000, fault});
    {ot, uv, dual, terr} = 4'hF;
    tick(1);
    {ot, uv, dual, terr} = 4'h0;
    tick(3);
    chk("latched", 12'h01C, {7'h00, flags});
    chk("pin", 12'h001, {11'h000, fault});
    cmd(8'hB1, 8'h00, 1'b1);
    chk("status1", 12'h007, {4'h0, rx});
    cmd(8'hFF, 8'h00, 1'b0);
    chk("cleared", 12'h000, {7'h00, flags, fault});
    ot = 1'b1;
    cmd(8'hFF, 8'h00, 1'b0);
    chk("live", 12'h021, {7'h00, flags, fault});
    {ot, ms, ps} = 3'b011;
    tick(1);
    {ms, ps} = 2'b00;
    cmd(8'hFF, 8'h00, 1'b0);
    chk("after", 12'h000, {7'h00, flags, fault});
    ms = 1'b1;
    tick(1);
    ms = 1'b0;
    tick(3);
    chk("short", 12'h005, {7'h00, flags, fault});
    cmd(8'hFF, 8'h00, 1'b0);
  endtask : t_faults

  task automatic t_pin();
    logic exp;
    proc = 4'b0110;
    play = 4'b1010;
    for (int s = 0; s < 2; s++)
      for (int c = 0; c < 4; c++)
      begin
        cmd({5'h18, s[0], c[1:0]}, 8'h00, 1'b0);
        exp = s[0] ? ~play[c] : ~proc[c];
        chk("pin", {11'h000, exp}, {11'h000, status});
      end
    play[3] = 1'b0;
    tick(3);
    chk("follow", 12'h001, {11'h000, status});
  endtask : t_pin

  initial
  begin
    {clock_i, rst_i, proc, play} = 10'h100;
    {ot, uv, dual, terr, ms, ps} = 6'h00;
    {mismatches, comparisons, cycles} = '0;
    repeat (10) @(posedge clock_i);
    #1 rst_i = 1'b0;
    tick(3);
    t_reset();
    t_volume();
    t_status();
    t_faults();
    t_pin();
    give_verdict();
  end
endmodule : vsc_top_tb

`default_nettype wire

// File: src/vsc_top.sv
`timescale 1ns/1ps
`default_nettype none

// Contract
// - volume command: 1010+channel bits, then 000+code
// - each selected channel takes the volume code
// - five-bit volume code, 32 levels
// - code maps to attenuation, code 00 mutes
// - volume codes are 1F after reset
// - reset or power-up reloads default volumes
// - status read select bit picks byte
// - select zero returns busy then ready flags
// - ready low while channel processes command
// - busy low while channel plays audio
// - select one returns zeros then three faults
// - fault raises fault pin and flag
// - fault clear command clears latched faults
// - overtemp flag set at temperature threshold
// - undervoltage flag set at voltage threshold
// - transfer flag set in duplicated mode errors
// - speaker short sets a short flag
// - pin select routes one flag to pin
// - source bit zero ready, one busy
// - binary channel index, channel 0 at reset
module vsc_top
  import vsc_pkg::*;
#(
  parameter int unsigned NUM_CH = vsc_pkg::VSC_NUM_CH
) (
  input  wire logic                         clock_i,
  input  wire logic                         rst_i,
  input  wire logic                         sclk_i,
  input  wire logic                         csn_i,
  input  wire logic                         si_i,
  output logic                              so_o,
  input  wire logic [NUM_CH-1:0]            ch_processing_i,
  input  wire logic [NUM_CH-1:0]            ch_playing_i,
  input  wire logic                         overtemp_detect_i,
  input  wire logic                         undervoltage_detect_i,
  input  wire logic                         dual_cmd_mode_i,
  input  wire logic                         transfer_error_i,
  input  wire logic                         minus_short_detect_i,
  input  wire logic                         plus_short_detect_i,
  output logic [NUM_CH-1:0][vsc_pkg::VSC_VOL_W-1:0] volume_code_o,
  output logic [NUM_CH-1:0][vsc_pkg::VSC_ATT_W-1:0] atten_cdb_o,
  output logic [NUM_CH-1:0]                 mute_o,
  output vsc_pkg::vsc_fault_t               fault_flags_o,
  output logic                              fault_o,
  output logic                              status_o
);
  import vsc_pkg::*;

  // ***************************************************************
  // live flags, core clock domain
  // ***************************************************************
  logic [NUM_CH-1:0] command_ready;
  logic [NUM_CH-1:0] playback_active_n;
  vsc_fault_t        flags_q;
  vsc_fault_t        flags_d;

  assign command_ready     = ~ch_processing_i;
  assign playback_active_n = ~ch_playing_i;

  // ***************************************************************
  // link side: shift in, status readout
  // ***************************************************************
  localparam int unsigned STAT_W = 2 * NUM_CH + 3;

  logic [2:0]        bit_cnt_q;
  logic              in_first_q;
  logic              readout_q;
  logic [6:0]        shift_in_q;
  logic [7:0]        shift_out_q;
  logic [7:0]        byte_in;
  vsc_word_t         word_q;
  logic              word_tog_q;
  logic [STAT_W-1:0] stat_meta_q;
  logic [STAT_W-1:0] stat_sync_q;
  logic [7:0]        ready_busy_byte;
  logic [7:0]        fault_byte;

  assign byte_in = {shift_in_q, si_i};

  // level flags only; a bit may lag two link clock edges
  always_ff @(posedge sclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      stat_meta_q <= '0;
      stat_sync_q <= '0;
    end
    else
    begin
      stat_meta_q <= {playback_active_n, command_ready,
                      flags_q.overtemp, flags_q.undervoltage,
                      flags_q.transfer};
      stat_sync_q <= stat_meta_q;
    end
  end

  assign ready_busy_byte = stat_sync_q[STAT_W-1:3];
  assign fault_byte      = {VSC_STAT_PAD, stat_sync_q[2:0]};

  // frame state ends with chip select, no link edge needed
  always_ff @(posedge sclk_i or posedge csn_i)
  begin
    if (csn_i)
    begin
      bit_cnt_q   <= '0;
      in_first_q  <= 1'b1;
      readout_q   <= 1'b0;
      shift_in_q  <= '0;
      shift_out_q <= '0;
    end
    else
    begin
      bit_cnt_q  <= bit_cnt_q + 3'h1;
      shift_in_q <= byte_in[6:0];
      if (bit_cnt_q == VSC_BIT_LAST)
      begin
        in_first_q <= 1'b0;
        readout_q  <= 1'b0;
        shift_out_q <= '0;
        if (in_first_q && byte_in[7:1] == VSC_STAT_READ_TOP)
        begin
          readout_q   <= 1'b1;
          shift_out_q <= byte_in[0] ? fault_byte : ready_busy_byte;
        end
      end
      else
      begin
        shift_out_q <= {shift_out_q[6:0], 1'b0};
      end
    end
  end

  assign so_o = shift_out_q[7];

  // readout bytes carry no command and are not forwarded
  always_ff @(posedge sclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      word_q     <= '0;
      word_tog_q <= 1'b0;
    end
    else if (!csn_i && bit_cnt_q == VSC_BIT_LAST && !readout_q)
    begin
      word_q     <= '{first: in_first_q, data: byte_in};
      word_tog_q <= ~word_tog_q;
    end
  end

  // ***************************************************************
  // word crossing into the core domain
  // ***************************************************************
  logic      tog_meta_q;
  logic      tog_sync_q;
  logic      tog_prev_q;
  logic      word_stb;
  vsc_word_t word_c;

  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      tog_meta_q <= 1'b0;
      tog_sync_q <= 1'b0;
      tog_prev_q <= 1'b0;
    end
    else
    begin
      tog_meta_q <= word_tog_q;
      tog_sync_q <= tog_meta_q;
      tog_prev_q <= tog_sync_q;
    end
  end

  // word_q stays put for a whole byte time, far beyond the sync delay
  assign word_stb = tog_sync_q ^ tog_prev_q;
  assign word_c   = word_q;

  // ***************************************************************
  // command decode
  // ***************************************************************
  logic              vol_cmd;
  logic              vol_data;
  logic              fault_clear_cmd;
  logic              power_up_cmd;
  logic              pin_sel_cmd;
  logic              vol_pend_q;
  logic [NUM_CH-1:0] channel_select_bits_q;

  assign vol_cmd  = word_stb && word_c.first &&
                    word_c.data[7:4] == VSC_VOL_NIBBLE;
  assign vol_data = word_stb && !word_c.first && vol_pend_q &&
                    word_c.data[7:5] == VSC_VOL_PAD;
  assign fault_clear_cmd = word_stb && word_c.first &&
                           word_c.data == VSC_FAULT_CLEAR_OP;
  assign power_up_cmd = word_stb && word_c.first &&
                        word_c.data == VSC_POWER_UP_OP;
  assign pin_sel_cmd = word_stb && word_c.first &&
                       word_c.data[7:3] == VSC_PIN_SEL_TOP;

  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      vol_pend_q            <= 1'b0;
      channel_select_bits_q <= '0;
    end
    else if (word_stb)
    begin
      vol_pend_q            <= vol_cmd;
      channel_select_bits_q <= word_c.data[NUM_CH-1:0];
    end
  end

  // ***************************************************************
  // channel volumes
  // ***************************************************************
  logic [NUM_CH-1:0][VSC_VOL_W-1:0] vol_q;

  always_ff @(posedge clock_i)
  begin
    if (rst_i || power_up_cmd)
    begin
      vol_q <= {NUM_CH{VSC_VOL_DEFAULT}};
    end
    else if (vol_data)
    begin
      for (int c = 0; c < NUM_CH; c++)
      begin
        // an empty channel mask leaves every channel alone
        if (channel_select_bits_q[c])
        begin
          vol_q[c] <= word_c.data[VSC_VOL_W-1:0];
        end
      end
    end
  end

  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      atten_cdb_o <= '0;
      mute_o      <= '0;
    end
    else
    begin
      for (int c = 0; c < NUM_CH; c++)
      begin
        atten_cdb_o[c] <= VSC_ATTEN_CDB[vol_q[c]];
        mute_o[c]      <= (vol_q[c] == VSC_VOL_MUTE);
      end
    end
  end

  assign volume_code_o = vol_q;

  // ***************************************************************
  // fail-safe flags
  // ***************************************************************
  vsc_fault_t cond;

  assign cond.overtemp     = overtemp_detect_i;
  assign cond.undervoltage = undervoltage_detect_i;
  assign cond.transfer     = transfer_error_i && dual_cmd_mode_i;
  assign cond.minus_short  = minus_short_detect_i;
  assign cond.plus_short   = plus_short_detect_i;

  // a live condition beats a clear arriving in the same cycle
  assign flags_d = (fault_clear_cmd ? '0 : flags_q) | cond;

  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      flags_q <= '0;
    end
    else
    begin
      flags_q <= flags_d;
    end
  end

  assign fault_flags_o = flags_q;
  assign fault_o       = |flags_q;

  // ***************************************************************
  // status pin routing
  // ***************************************************************
  logic       pin_src_q;
  logic [1:0] pin_ch_q;

  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      {pin_src_q, pin_ch_q} <= VSC_PIN_SEL_RESET;
    end
    else if (pin_sel_cmd)
    begin
      {pin_src_q, pin_ch_q} <= word_c.data[2:0];
    end
  end

  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      status_o <= 1'b1;
    end
    else
    begin
      status_o <= pin_src_q ? playback_active_n[pin_ch_q]
                            : command_ready[pin_ch_q];
    end
  end

  // ***************************************************************
  // checks
  // ***************************************************************
  AST_VOL_RESET: assert property (
    @(posedge clock_i) $past(rst_i) |->
      vol_q == {NUM_CH{VSC_VOL_DEFAULT}})
    else $error("volume not default after reset");

  AST_VOL_PUP: assert property (
    @(posedge clock_i) disable iff (rst_i)
      power_up_cmd |=> vol_q == {NUM_CH{VSC_VOL_DEFAULT}})
    else $error("power-up did not reload volumes");

  AST_VOL_APPLY: assert property (
    @(posedge clock_i) disable iff (rst_i)
      vol_data && channel_select_bits_q[0] |=>
        vol_q[0] == $past(word_c.data[4:0]))
    else $error("selected channel missed volume");

  AST_VOL_KEEP: assert property (
    @(posedge clock_i) disable iff (rst_i)
      !vol_data && !power_up_cmd |=> $stable(vol_q))
    else $error("volume changed without command");

  AST_MUTE: assert property (
    @(posedge clock_i) disable iff (rst_i)
      vol_q[3] == VSC_VOL_MUTE ##1 !$past(rst_i) |->
        mute_o[3] && atten_cdb_o[3] == VSC_ATT_MUTE)
    else $error("code zero did not mute");

  AST_FAULT_SET: assert property (
    @(posedge clock_i) disable iff (rst_i)
      overtemp_detect_i |=> flags_q.overtemp && fault_o)
    else $error("fault not flagged");

  AST_FAULT_HOLD: assert property (
    @(posedge clock_i) disable iff (rst_i)
      flags_q.undervoltage && !fault_clear_cmd |=>
        flags_q.undervoltage [*1])
    else $error("fault flag dropped without clear");

  AST_FAULT_CLR: assert property (
    @(posedge clock_i) disable iff (rst_i)
      fault_clear_cmd && cond == '0 |=> !fault_o)
    else $error("fault clear failed");

  AST_PIN_ROUTE: assert property (
    @(posedge clock_i) disable iff (rst_i)
      !$past(rst_i) |-> status_o == ($past(pin_src_q) ?
        $past(playback_active_n[pin_ch_q]) :
        $past(command_ready[pin_ch_q])))
    else $error("status pin routing wrong");

  AST_PIN_RESET: assert property (
    @(posedge clock_i) $past(rst_i) |->
      pin_src_q == 1'b0 && pin_ch_q == 2'h0)
    else $error("pin select not channel 0 ready");

endmodule : vsc_top

`default_nettype wire
